// ### design/ssp_pkg.sv
// Shared constants and types for the serial port pin function block
package ssp_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SYS_CLK_PERIOD_NS = 20;
	localparam int BIT_CLK_PERIOD_NS = 160;
	// Half period of the generated bit clock, rounded down, never below one cycle
	localparam int BIT_CLK_HALF_CYC  = (BIT_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS) < 1) ? 1 :
		BIT_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);

	// ----------------------------------------
	// Data path
	// ----------------------------------------
	localparam int WORD_BITS     = 16;
	localparam int TX_FIFO_DEPTH = 8;

	// ----------------------------------------
	// Pin positions
	// ----------------------------------------
	localparam int PIN_TX_DATA  = 0;
	localparam int PIN_RX_DATA  = 1;
	localparam int PIN_BIT_CLK  = 2;
	localparam int PIN_CTRL0    = 3;
	localparam int PIN_CTRL1    = 4;
	localparam int PIN_CTRL2_FS = 5;
	localparam int NUM_PINS     = 6;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [5:0] PIN_OE_N_RST = 6'h3f;
	localparam logic [5:0] PIN_OUT_RST  = 6'h00;

	typedef enum logic {TX_IDLE, TX_SHIFT} ssp_tx_state_type;
	typedef enum logic {RX_IDLE, RX_SHIFT} ssp_rx_state_type;

endpackage

// ### design/ssp_sync2.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module ssp_sync2 #(
	parameter int W = 6
) (
	// Clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_resetn,
	// Levels
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} ssp_sync_type;

	ssp_sync_type s_reg;
	ssp_sync_type s_next;

	if (W < 1) begin : g_chk
		$error("ssp_sync2: W must be at least 1");
	end

	always_comb begin
		s_next.meta   = i_async;
		s_next.stable = s_reg.meta;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_sync = s_reg.stable;
endmodule

// ### design/ssp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module ssp_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	// Clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_resetn,
	// Fill side
	input  wire logic [W-1:0] i_wr_data,
	input  wire logic         i_wr_valid,
	output logic              o_wr_ready,
	// Drain side
	output logic      [W-1:0] o_rd_data,
	output logic              o_rd_valid,
	input  wire logic         i_rd_ready
);
	localparam int PW = (D > 1) ? $clog2(D) : 1;

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [PW-1:0]       wr_ptr;
		logic [PW-1:0]       rd_ptr;
		logic [PW:0]         count;
	} ssp_fifo_type;

	ssp_fifo_type s_reg;
	ssp_fifo_type s_next;
	logic         push;
	logic         pop;

	if (D < 2 || W < 1) begin : g_chk
		$error("ssp_fifo: depth below 2 or zero width");
	end

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(D - 1)) ? '0 : p + 1'b1;
	endfunction

	assign o_wr_ready = (s_reg.count != (PW+1)'(D));
	assign o_rd_valid = (s_reg.count != '0);
	assign o_rd_data  = s_reg.mem[s_reg.rd_ptr];
	assign push       = i_wr_valid && o_wr_ready;
	assign pop        = i_rd_ready && o_rd_valid;

	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.mem[s_reg.wr_ptr] = i_wr_data;
			s_next.wr_ptr            = bump(s_reg.wr_ptr);
		end
		if (pop) begin
			s_next.rd_ptr = bump(s_reg.rd_ptr);
		end
		s_next.count = s_reg.count + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule

// ### design/ssp_pins.sv
// Serial port pin functions: shifters, bit clock, frame syncs and GPIO fallback
`timescale 1ns/100ps
module ssp_pins
	import ssp_pkg::*;
#(
	parameter int WW       = WORD_BITS,
	parameter int DEPTH    = TX_FIFO_DEPTH,
	parameter int HALF_CYC = BIT_CLK_HALF_CYC
) (
	// Clock and reset
	input  wire logic          i_sys_clk,
	input  wire logic          i_resetn,
	// Configuration
	input  wire logic          i_port_en,
	input  wire logic          i_cfg_sync_mode,
	input  wire logic          i_cfg_gated_clk,
	input  wire logic          i_cfg_sck_out,
	input  wire logic          i_cfg_rck_out,
	input  wire logic          i_cfg_rfs_out,
	input  wire logic          i_cfg_fs_out,
	input  wire logic          i_cfg_ctrl0_tx,
	input  wire logic          i_cfg_ctrl1_tx,
	input  wire logic [1:0]    i_cfg_flag_dir,
	// General-purpose I/O
	input  wire logic [5:0]    i_gpio_sel,
	input  wire logic [5:0]    i_gpio_dir,
	input  wire logic [5:0]    i_gpio_out,
	output logic      [5:0]    o_gpio_in,
	// Serial flags
	input  wire logic [1:0]    i_flag_out,
	output logic      [1:0]    o_flag_in,
	// Transmit words
	input  wire logic [WW-1:0] i_tx_word,
	input  wire logic          i_tx_valid,
	output logic               o_tx_ready,
	input  wire logic [WW-1:0] i_tx2_word,
	input  wire logic [WW-1:0] i_tx3_word,
	// Receive words
	output logic      [WW-1:0] o_rx_word,
	output logic               o_rx_valid,
	// Pins
	input  wire logic          i_ser1_tx_data,
	output logic               o_ser1_tx_data,
	output logic               o_ser1_tx_data_oe_n,
	input  wire logic          i_ser1_rx_data,
	output logic               o_ser1_rx_data,
	output logic               o_ser1_rx_data_oe_n,
	input  wire logic          i_ser1_bit_clock,
	output logic               o_ser1_bit_clock,
	output logic               o_ser1_bit_clock_oe_n,
	input  wire logic          i_ser1_ctrl0,
	output logic               o_ser1_ctrl0,
	output logic               o_ser1_ctrl0_oe_n,
	input  wire logic          i_ser1_ctrl1,
	output logic               o_ser1_ctrl1,
	output logic               o_ser1_ctrl1_oe_n,
	input  wire logic          i_ser1_ctrl2_frame_sync,
	output logic               o_ser1_ctrl2_frame_sync,
	output logic               o_ser1_ctrl2_frame_sync_oe_n
);
	localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
	localparam int BW = $clog2(WW);

	if (HALF_CYC < 1 || WW < 2 || DEPTH < 2) begin : g_chk
		$error("ssp_pins: unsupported parameter values");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [CW-1:0]        div_cnt;
		logic                 sck_int;
		logic                 tck_prev;
		logic                 rck_prev;
		ssp_tx_state_type     tx_st;
		logic [WW-1:0]        tx_sh;
		logic [WW-1:0]        tx2_sh;
		logic [WW-1:0]        tx3_sh;
		logic [BW-1:0]        tx_cnt;
		logic                 fs_drive;
		logic [BW-1:0]        rg_cnt;
		logic                 rfs_gen;
		ssp_rx_state_type     rx_st;
		logic [WW-1:0]        rx_sh;
		logic [BW-1:0]        rx_cnt;
		logic [WW-1:0]        rx_word;
		logic                 rx_valid;
		logic [NUM_PINS-1:0]  pin_out;
		logic [NUM_PINS-1:0]  pin_oe_n;
	} ssp_state_type;

	ssp_state_type       s_reg;
	ssp_state_type       s_next;
	logic [NUM_PINS-1:0] pin_in;
	logic [NUM_PINS-1:0] pin_sync;
	logic [WW-1:0]       fifo_data;
	logic                fifo_vld;
	logic                fifo_pop;
	logic                clk_run;
	logic                tick;
	logic                tx_rise;
	logic                tx_fall;
	logic                rx_rise;
	logic                rx_fall;
	logic                tx_start;
	logic                tx_fs;
	logic                rx_fs;
	logic                rx_bit;

	// ----------------------------------------
	// Pin sampling and transmit buffer
	// ----------------------------------------
	assign pin_in = {i_ser1_ctrl2_frame_sync, i_ser1_ctrl1, i_ser1_ctrl0,
		i_ser1_bit_clock, i_ser1_rx_data, i_ser1_tx_data};

	ssp_sync2 #(
		.W(NUM_PINS)
	) ssp_sync2_i (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_async   (pin_in),
		.o_sync    (pin_sync)
	);

	ssp_fifo #(
		.W(WW),
		.D(DEPTH)
	) ssp_fifo_i (
		.i_sys_clk  (i_sys_clk),
		.i_resetn   (i_resetn),
		.i_wr_data  (i_tx_word),
		.i_wr_valid (i_tx_valid),
		.o_wr_ready (o_tx_ready),
		.o_rd_data  (fifo_data),
		.o_rd_valid (fifo_vld),
		.i_rd_ready (fifo_pop)
	);

	// ----------------------------------------
	// Clock edges and frame sync sources
	// ----------------------------------------
	// Gated clock parks low between frames so the partner sees no stray edge
	assign clk_run = !i_cfg_gated_clk || s_reg.tx_st == TX_SHIFT || fifo_vld;
	assign tick    = (s_reg.div_cnt == CW'(HALF_CYC - 1)) && (clk_run || s_reg.sck_int);

	always_comb begin
		if (i_cfg_sck_out) begin
			tx_rise = tick && !s_reg.sck_int;
			tx_fall = tick && s_reg.sck_int;
		end else begin
			tx_rise = pin_sync[PIN_BIT_CLK] && !s_reg.tck_prev;
			tx_fall = !pin_sync[PIN_BIT_CLK] && s_reg.tck_prev;
		end
		if (i_cfg_sync_mode) begin
			rx_rise = tx_rise;
			rx_fall = tx_fall;
		end else if (i_cfg_rck_out) begin
			rx_rise = tick && !s_reg.sck_int;
			rx_fall = tick && s_reg.sck_int;
		end else begin
			rx_rise = pin_sync[PIN_CTRL0] && !s_reg.rck_prev;
			rx_fall = !pin_sync[PIN_CTRL0] && s_reg.rck_prev;
		end
	end

	// Internal frame sync starts a frame when the last bit is out
	assign tx_fs = i_cfg_fs_out ?
		((s_reg.tx_st == TX_IDLE || s_reg.tx_cnt == '0) && (!i_cfg_gated_clk || fifo_vld)) :
		pin_sync[PIN_CTRL2_FS];
	assign tx_start = tx_rise && tx_fs;
	assign fifo_pop = tx_start && fifo_vld;

	always_comb begin
		if (i_cfg_sync_mode) begin
			rx_fs = i_cfg_fs_out ? s_reg.fs_drive : pin_sync[PIN_CTRL2_FS];
		end else begin
			rx_fs = i_cfg_rfs_out ? s_reg.rfs_gen : pin_sync[PIN_CTRL1];
		end
	end
	assign rx_bit = pin_sync[PIN_RX_DATA];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_next          = s_reg;
		s_next.rx_valid = 1'b0;
		s_next.tck_prev = pin_sync[PIN_BIT_CLK];
		s_next.rck_prev = pin_sync[PIN_CTRL0];

		// Bit clock divider
		if (tick) begin
			s_next.div_cnt = '0;
			s_next.sck_int = !s_reg.sck_int;
		end else if (clk_run || s_reg.sck_int) begin
			s_next.div_cnt = s_reg.div_cnt + 1'b1;
		end

		// Transmit shifters, changed on the rising bit clock edge
		if (tx_rise) begin
			s_next.fs_drive = 1'b0;
			if (tx_start) begin
				s_next.tx_sh    = fifo_vld ? fifo_data : '0;
				s_next.tx2_sh   = i_tx2_word;
				s_next.tx3_sh   = i_tx3_word;
				s_next.tx_cnt   = BW'(WW - 1);
				s_next.fs_drive = 1'b1;
				s_next.tx_st    = TX_SHIFT;
			end else begin
				case (s_reg.tx_st)
					TX_SHIFT: begin
						s_next.tx_sh  = {s_reg.tx_sh[WW-2:0], 1'b0};
						s_next.tx2_sh = {s_reg.tx2_sh[WW-2:0], 1'b0};
						s_next.tx3_sh = {s_reg.tx3_sh[WW-2:0], 1'b0};
						if (s_reg.tx_cnt == '0) begin
							s_next.tx_st = TX_IDLE;
						end else begin
							s_next.tx_cnt = s_reg.tx_cnt - 1'b1;
						end
					end
					default: begin
						s_next.tx_st = TX_IDLE;
					end
				endcase
			end
		end

		// Receive frame sync generator for asynchronous mode
		if (rx_rise) begin
			s_next.rfs_gen = (s_reg.rg_cnt == '0);
			s_next.rg_cnt  = (s_reg.rg_cnt == '0) ? BW'(WW - 1) : s_reg.rg_cnt - 1'b1;
		end

		// Receive shifter, sampled on the falling bit clock edge
		if (rx_fall) begin
			if (rx_fs) begin
				s_next.rx_sh  = {{(WW-1){1'b0}}, rx_bit};
				s_next.rx_cnt = BW'(WW - 2);
				s_next.rx_st  = RX_SHIFT;
			end else begin
				case (s_reg.rx_st)
					RX_SHIFT: begin
						s_next.rx_sh = {s_reg.rx_sh[WW-2:0], rx_bit};
						if (s_reg.rx_cnt == '0) begin
							s_next.rx_word  = {s_reg.rx_sh[WW-2:0], rx_bit};
							s_next.rx_valid = 1'b1;
							s_next.rx_st    = RX_IDLE;
						end else begin
							s_next.rx_cnt = s_reg.rx_cnt - 1'b1;
						end
					end
					default: begin
						s_next.rx_st = RX_IDLE;
					end
				endcase
			end
		end

		// Serial pin functions
		s_next.pin_out  = '0;
		s_next.pin_oe_n = '1;
		s_next.pin_out[PIN_TX_DATA]  = s_reg.tx_sh[WW-1];
		s_next.pin_oe_n[PIN_TX_DATA] = 1'b0;
		s_next.pin_out[PIN_BIT_CLK]  = s_reg.sck_int;
		s_next.pin_oe_n[PIN_BIT_CLK] = !i_cfg_sck_out;
		if (i_cfg_sync_mode) begin
			if (i_cfg_ctrl0_tx) begin
				s_next.pin_out[PIN_CTRL0]  = s_reg.tx2_sh[WW-1];
				s_next.pin_oe_n[PIN_CTRL0] = 1'b0;
			end else begin
				s_next.pin_out[PIN_CTRL0]  = i_flag_out[0];
				s_next.pin_oe_n[PIN_CTRL0] = !i_cfg_flag_dir[0];
			end
			if (i_cfg_ctrl1_tx) begin
				s_next.pin_out[PIN_CTRL1]  = s_reg.tx3_sh[WW-1];
				s_next.pin_oe_n[PIN_CTRL1] = 1'b0;
			end else begin
				s_next.pin_out[PIN_CTRL1]  = i_flag_out[1];
				s_next.pin_oe_n[PIN_CTRL1] = !i_cfg_flag_dir[1];
			end
		end else begin
			s_next.pin_out[PIN_CTRL0]  = s_reg.sck_int;
			s_next.pin_oe_n[PIN_CTRL0] = !i_cfg_rck_out;
			s_next.pin_out[PIN_CTRL1]  = s_reg.rfs_gen;
			s_next.pin_oe_n[PIN_CTRL1] = !i_cfg_rfs_out;
		end
		s_next.pin_out[PIN_CTRL2_FS]  = s_reg.fs_drive;
		s_next.pin_oe_n[PIN_CTRL2_FS] = !i_cfg_fs_out;

		// General-purpose fallback per pin, or for all pins with the port off
		for (int i = 0; i < NUM_PINS; i++) begin
			if (!i_port_en || i_gpio_sel[i]) begin
				s_next.pin_out[i]  = i_gpio_out[i];
				s_next.pin_oe_n[i] = !i_gpio_dir[i];
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_reg          <= '0;
			s_reg.tx_st    <= TX_IDLE;
			s_reg.rx_st    <= RX_IDLE;
			s_reg.pin_out  <= PIN_OUT_RST;
			s_reg.pin_oe_n <= PIN_OE_N_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_gpio_in  = pin_sync;
	assign o_flag_in  = pin_sync[PIN_CTRL1:PIN_CTRL0];
	assign o_rx_word  = s_reg.rx_word;
	assign o_rx_valid = s_reg.rx_valid;
	assign o_ser1_tx_data               = s_reg.pin_out[PIN_TX_DATA];
	assign o_ser1_tx_data_oe_n          = s_reg.pin_oe_n[PIN_TX_DATA];
	assign o_ser1_rx_data               = s_reg.pin_out[PIN_RX_DATA];
	assign o_ser1_rx_data_oe_n          = s_reg.pin_oe_n[PIN_RX_DATA];
	assign o_ser1_bit_clock             = s_reg.pin_out[PIN_BIT_CLK];
	assign o_ser1_bit_clock_oe_n        = s_reg.pin_oe_n[PIN_BIT_CLK];
	assign o_ser1_ctrl0                 = s_reg.pin_out[PIN_CTRL0];
	assign o_ser1_ctrl0_oe_n            = s_reg.pin_oe_n[PIN_CTRL0];
	assign o_ser1_ctrl1                 = s_reg.pin_out[PIN_CTRL1];
	assign o_ser1_ctrl1_oe_n            = s_reg.pin_oe_n[PIN_CTRL1];
	assign o_ser1_ctrl2_frame_sync      = s_reg.pin_out[PIN_CTRL2_FS];
	assign o_ser1_ctrl2_frame_sync_oe_n = s_reg.pin_oe_n[PIN_CTRL2_FS];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	chk_gpio_port_off: assert property (
		!i_port_en |=> s_reg.pin_oe_n == ~$past(i_gpio_dir) && s_reg.pin_out == $past(i_gpio_out))
		else $error("pins not in GPIO while port off");
	chk_bit_clock_drive: assert property (
		i_port_en && !i_gpio_sel[PIN_BIT_CLK] && i_cfg_sck_out |=>
		!s_reg.pin_oe_n[PIN_BIT_CLK] && s_reg.pin_out[PIN_BIT_CLK] == $past(s_reg.sck_int))
		else $error("bit clock pin not driven with internal clock");
	chk_gated_clock_idle: assert property (
		i_cfg_gated_clk && !clk_run && !s_reg.sck_int && $stable(i_cfg_gated_clk) [*2]
		|-> !s_reg.sck_int && s_reg.div_cnt == $past(s_reg.div_cnt))
		else $error("gated bit clock moved while idle");
	chk_sync_shared_clock: assert property (
		i_cfg_sync_mode |-> rx_fall == tx_fall && rx_rise == tx_rise)
		else $error("receiver not on shared bit clock");
	chk_async_rx_clock: assert property (
		!i_cfg_sync_mode && !i_cfg_rck_out |->
		rx_fall == (!pin_sync[PIN_CTRL0] && $past(pin_sync[PIN_CTRL0])))
		else $error("receive clock not taken from control pin 0");
	chk_ctrl0_second_tx: assert property (
		i_port_en && !i_gpio_sel[PIN_CTRL0] && i_cfg_sync_mode && i_cfg_ctrl0_tx |=>
		!s_reg.pin_oe_n[PIN_CTRL0] && s_reg.pin_out[PIN_CTRL0] == $past(s_reg.tx2_sh[WW-1]))
		else $error("control pin 0 not second transmitter");
	chk_ctrl1_third_tx: assert property (
		i_port_en && !i_gpio_sel[PIN_CTRL1] && i_cfg_sync_mode && i_cfg_ctrl1_tx |=>
		!s_reg.pin_oe_n[PIN_CTRL1] && s_reg.pin_out[PIN_CTRL1] == $past(s_reg.tx3_sh[WW-1]))
		else $error("control pin 1 not third transmitter");
	chk_frame_sync_out: assert property (
		i_port_en && !i_gpio_sel[PIN_CTRL2_FS] && i_cfg_fs_out |=>
		!s_reg.pin_oe_n[PIN_CTRL2_FS] && s_reg.pin_out[PIN_CTRL2_FS] == $past(s_reg.fs_drive))
		else $error("frame sync pin not carrying internal frame sync");
	chk_ext_fs_start: assert property (
		!i_cfg_fs_out && tx_rise && pin_sync[PIN_CTRL2_FS] |=>
		s_reg.tx_st == TX_SHIFT && s_reg.tx_cnt == BW'(WW - 1))
		else $error("external frame sync did not start a frame");
	chk_tx_data_pin: assert property (
		i_port_en && !i_gpio_sel[PIN_TX_DATA] |=>
		!s_reg.pin_oe_n[PIN_TX_DATA] && s_reg.pin_out[PIN_TX_DATA] == $past(s_reg.tx_sh[WW-1]))
		else $error("transmit pin not carrying shift register bit");

	cov_tx_frame: cover property (fifo_pop);
	cov_rx_word: cover property (s_reg.rx_valid);
	cov_async_rx: cover property (!i_cfg_sync_mode && s_reg.rx_valid);
endmodule

// ### verification/ssp_codec_model.sv
// Behavioural serial codec standing at the far side of the port pins
`timescale 1ns/100ps
module ssp_codec_model (
	// Control from the bench
	input  wire logic        i_sys_clk,
	input  wire logic        i_ext_en,
	input  wire logic [15:0] i_rx_word,
	// Resolved pin levels and what this side drives
	input  wire logic [5:0]  i_line,
	output logic      [5:0]  o_drive,
	// Captured frames
	output logic      [15:0] o_got_tx,
	output logic      [15:0] o_got_tx2,
	output logic      [15:0] o_got_tx3,
	output int               o_n_got
);
	logic        bclk = 1'b0;
	logic        fs   = 1'b0;
	logic        rxd  = 1'b0;
	logic        tog  = 1'b0;
	logic        act  = 1'b0;
	logic [15:0] sh0, sh1, sh2;
	int          idx  = 0;
	int          nf   = 0;
	int          nbit = 0;

	initial begin
		o_n_got = 0;
	end

	// Undriven lines 0, 3 and 4, and line 5 with the external clock off, never hold their last value
	always @(posedge i_sys_clk) begin
		tog <= ~tog;
	end

	// ----------------------------------------
	// External bit clock and frame sync
	// ----------------------------------------
	// Odd start offset keeps the link out of phase with the system clock
	initial begin
		#7;
		forever begin
			#80;
			bclk = i_ext_en ? ~bclk : 1'b0;
		end
	end

	// Sync spans the frame's first rise and fall, clear of both edges
	always @(negedge bclk) begin
		nf = (nf + 1) % 16;
		fs <= #40 (nf == 15);
	end

	// ----------------------------------------
	// Serial data on the resolved lines
	// ----------------------------------------
	always @(posedge i_line[2]) begin
		#1;
		if (i_line[5]) begin
			idx  = 15;
			act  = 1'b1;
			nbit = 0;
		end else if (idx > 0) begin
			idx--;
		end
		rxd = act ? i_rx_word[idx] : ~rxd;
	end

	always @(negedge i_line[2]) begin
		if (act) begin
			sh0 = {sh0[14:0], i_line[0]};
			sh1 = {sh1[14:0], i_line[3]};
			sh2 = {sh2[14:0], i_line[4]};
			nbit++;
			if (nbit == 16) begin
				o_got_tx  = sh0;
				o_got_tx2 = sh1;
				o_got_tx3 = sh2;
				o_n_got++;
				act = 1'b0;
			end
		end
	end

	assign o_drive = {i_ext_en ? fs : tog, tog, tog, bclk, rxd, tog};
endmodule

// ### verification/ssp_pins_tb.sv
// Self-checking testbench for the serial port pin function block
`timescale 1ns/100ps
module ssp_pins_tb;
	import ssp_pkg::*;
	logic        sys_clk = 1'b0;
	logic        resetn  = 1'b0;
	logic [8:0]  cfg     = 9'h000;
	logic [1:0]  fdir    = 2'h0;
	logic [1:0]  fout    = 2'h0;
	logic [5:0]  gsel    = 6'h00;
	logic [5:0]  gdir    = 6'h00;
	logic [5:0]  gout    = 6'h00;
	logic [15:0] txw     = 16'h0000;
	logic        txv     = 1'b0;
	logic        ext_en  = 1'b0;
	logic [15:0] rxw     = 16'ha5c3;
	logic        tbm     = 1'b0;
	logic [5:0]  tbv     = 6'h00;
	logic [5:0]  gin, oe_n, pout, mdl;
	logic [1:0]  flag_in;
	logic [15:0] rx_word, got0, got2, got3;
	logic        tx_ready, rx_valid;
	wire  [5:0]  line;
	int          n_got;
	int          n_errors    = 0;
	int          checks_done = 0;
	int          cyc         = 0;

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	genvar g;
	for (g = 0; g < 6; g++) begin : g_pin
		assign line[g] = !oe_n[g] ? pout[g] : (tbm ? tbv[g] : mdl[g]);
	end

	ssp_pins ssp_pins_i (
		.i_sys_clk(sys_clk), .i_resetn(resetn), .i_port_en(cfg[8]),
		.i_cfg_sync_mode(cfg[7]), .i_cfg_gated_clk(cfg[6]), .i_cfg_sck_out(cfg[5]),
		.i_cfg_rck_out(cfg[4]), .i_cfg_rfs_out(cfg[3]), .i_cfg_fs_out(cfg[2]),
		.i_cfg_ctrl0_tx(cfg[1]), .i_cfg_ctrl1_tx(cfg[0]), .i_cfg_flag_dir(fdir),
		.i_gpio_sel(gsel), .i_gpio_dir(gdir), .i_gpio_out(gout), .o_gpio_in(gin),
		.i_flag_out(fout), .o_flag_in(flag_in), .i_tx_word(txw), .i_tx_valid(txv),
		.o_tx_ready(tx_ready), .i_tx2_word(16'h5678), .i_tx3_word(16'h9abc),
		.o_rx_word(rx_word), .o_rx_valid(rx_valid),
		.i_ser1_tx_data(line[0]), .o_ser1_tx_data(pout[0]), .o_ser1_tx_data_oe_n(oe_n[0]),
		.i_ser1_rx_data(line[1]), .o_ser1_rx_data(pout[1]), .o_ser1_rx_data_oe_n(oe_n[1]),
		.i_ser1_bit_clock(line[2]), .o_ser1_bit_clock(pout[2]),
		.o_ser1_bit_clock_oe_n(oe_n[2]),
		.i_ser1_ctrl0(line[3]), .o_ser1_ctrl0(pout[3]), .o_ser1_ctrl0_oe_n(oe_n[3]),
		.i_ser1_ctrl1(line[4]), .o_ser1_ctrl1(pout[4]), .o_ser1_ctrl1_oe_n(oe_n[4]),
		.i_ser1_ctrl2_frame_sync(line[5]), .o_ser1_ctrl2_frame_sync(pout[5]),
		.o_ser1_ctrl2_frame_sync_oe_n(oe_n[5]));

	ssp_codec_model ssp_codec_model_i (
		.i_sys_clk(sys_clk), .i_ext_en(ext_en), .i_rx_word(rxw), .i_line(line),
		.o_drive(mdl), .o_got_tx(got0), .o_got_tx2(got2), .o_got_tx3(got3),
		.o_n_got(n_got));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic push(input logic [15:0] w);
		@(posedge sys_clk);
		txw <= w;
		txv <= 1'b1;
		@(posedge sys_clk);
		txv <= 1'b0;
	endtask

	// Frames may hold idle zeros first, so wait for the word itself
	task automatic wait_got(input logic [15:0] exp);
		for (int k = 0; k < 3000 && got0 !== exp; k++) tick(1);
		check(got0, exp);
		check(got2, 16'h5678);
		check(got3, 16'h9abc);
	endtask

	task automatic wait_rx(input logic [15:0] exp);
		for (int k = 0; k < 3000 && !(rx_valid === 1'b1 && rx_word === exp); k++) tick(1);
		check(rx_word, exp);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_gpio;
		@(posedge sys_clk);
		gdir <= 6'h3f;
		gout <= 6'h2d;
		tick(2);
		check(oe_n, 6'h00);
		check(pout, 6'h2d);
		gdir <= 6'h00;
		tbm  <= 1'b1;
		tbv  <= 6'h15;
		tick(4);
		check(oe_n, 6'h3f);
		check(gin, 6'h15);
		cfg  <= 9'h1a7;
		gsel <= 6'h01;
		gdir <= 6'h01;
		gout <= 6'h01;
		tbm  <= 1'b0;
		tick(3);
		check({oe_n[2:0], pout[0]}, 4'h5);
		gsel <= 6'h00;
	endtask

	task automatic s_sync_int;
		push(16'h1234);
		wait_got(16'h1234);
		wait_rx(16'ha5c3);
		check(oe_n, 6'h02);
	endtask

	task automatic s_ext;
		@(posedge sys_clk);
		cfg    <= 9'h183;
		ext_en <= 1'b1;
		rxw    <= 16'h3c5a;
		tick(2);
		check({oe_n[5], oe_n[2]}, 2'h3);
		push(16'h0f0e);
		wait_got(16'h0f0e);
		wait_rx(16'h3c5a);
		ext_en <= 1'b0;
	endtask

	task automatic s_fifo;
		int n, hi;
		@(posedge sys_clk);
		cfg <= 9'h000;
		tick(40);
		for (int i = 0; i < 9; i++) begin
			txw <= 16'hc000 + 16'(i);
			txv <= 1'b1;
			@(posedge sys_clk);
		end
		txv <= 1'b0;
		#1;
		check(tx_ready, 1'b0);
		cfg <= 9'h1e7;
		for (int i = 0; i < 8; i++) begin
			n = n_got;
			for (int k = 0; k < 400 && n_got == n; k++) tick(1);
			check(got0, 16'hc000 + 16'(i));
		end
		check(tx_ready, 1'b1);
		tick(40);
		hi = 0;
		for (int k = 0; k < 200; k++) begin
			tick(1);
			hi += line[2];
		end
		check(16'(hi), 16'h0000);
	endtask

	task automatic s_flags;
		int tg;
		logic last;
		@(posedge sys_clk);
		cfg  <= 9'h1a4;
		fdir <= 2'h1;
		fout <= 2'h1;
		tbm  <= 1'b1;
		tbv  <= 6'h10;
		tick(4);
		check({oe_n[4:3], pout[3]}, 3'h5);
		check(flag_in, 2'h3);
		cfg <= 9'h13c;
		tbm <= 1'b0;
		tick(3);
		check(oe_n[5:3], 3'h0);
		tg   = 0;
		last = line[3];
		for (int k = 0; k < 40; k++) begin
			tick(1);
			tg  += (line[3] != last);
			last = line[3];
		end
		check(tg > 0, 1'b1);
		cfg <= 9'h124;
		tick(3);
		check(oe_n[5:3], 3'h3);
	endtask

	// ----------------------------------------
	// Main sequence and timeout
	// ----------------------------------------
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			conclude();
		end
	end

	initial begin
		tick(19);
		check(oe_n, 6'h3f);
		check({tx_ready, rx_valid}, 2'h2);
		@(posedge sys_clk);
		resetn <= 1'b1;
		s_gpio();
		s_sync_int();
		s_ext();
		s_fifo();
		s_flags();
		conclude();
	end
endmodule
